// ### hdl/wdt_pkg.sv
package wdt_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_GUARD = 8'h00;
  localparam logic [7:0] OFS_CLKCTL = 8'h04;
  localparam logic [7:0] OFS_PWR = 8'h08;
  localparam logic [7:0] OFS_IE = 8'h0C;
  localparam logic [7:0] OFS_XIE = 8'h10;
  localparam logic [7:0] OFS_XIP = 8'h14;
  localparam logic [7:0] OFS_TA = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_MASK = 8'h20;
  // guard control fields
  localparam int GD_TOF = 3;
  localparam int GD_RCF = 2;
  localparam int GD_RFE = 1;
  localparam int GD_RST = 0;
  // clock control, power, interrupt enable and priority fields
  localparam int PS_HI = 7;
  localparam int PS_LO = 6;
  localparam int CD_HI = 7;
  localparam int CD_LO = 6;
  localparam int MULT_BIT = 3;
  localparam int GIE_BIT = 7;
  localparam int TOIE_BIT = 4;
  localparam int TOIP_BIT = 4;
  // status / mask fields
  localparam int ST_TO = 0;
  localparam int ST_WR = 1;
  localparam int ST_W = 2;
  // reset values and encodings
  localparam logic [1:0] CD_MULT = 2'h0;
  localparam logic [1:0] CD_PMM = 2'h3;
  localparam logic [1:0] CD_RESET = 2'h2;
  localparam logic [1:0] PS_RESET = 2'h0;
  // timeout exponents
  localparam logic [5:0] EXP_X4 = 6'h0F;
  localparam logic [5:0] EXP_X2 = 6'h10;
  localparam logic [5:0] EXP_STD = 6'h11;
  localparam logic [5:0] EXP_PMM = 6'h19;
  localparam logic [5:0] EXP_STEP = 6'h03;
  localparam int EXP_MAX = 34;
  // grace time before the core reset, in system clocks
  localparam int GRACE_CLKS = 512;
  // timed access keys and window, in clocks
  localparam logic [7:0] TA_KEY1 = 8'hAA;
  localparam logic [7:0] TA_KEY2 = 8'h55;
  localparam int TA_WINDOW = 8;
  // interrupt identity
  localparam logic [7:0] IRQ_VECTOR = 8'h63;
  localparam logic [3:0] IRQ_RANK = 4'hE;

  typedef enum logic [1:0] {
    TA_IDLE = 2'h0,
    TA_HALF = 2'h1,
    TA_OPEN = 2'h3
  } wdt_ta_state_t;

  typedef enum logic {
    WD_RUN = 1'b0,
    WD_GRACE = 1'b1
  } wdt_wd_state_t;

  // timeout exponent from divide field, multiplier and period select
  function automatic logic [5:0] wdt_exponent(input logic [1:0] cd, input logic mult,
                                             input logic [1:0] ps);
    logic [5:0] base;
    base = EXP_STD;
    if (cd == CD_PMM) begin
      base = EXP_PMM;
    end else if (cd == CD_MULT) begin
      base = mult ? EXP_X4 : EXP_X2;
    end
    wdt_exponent = base + EXP_STEP * {4'h0, ps};
  endfunction : wdt_exponent
endpackage : wdt_pkg

// ### hdl/wdt_count_chain.sv
`timescale 1ns/1ns
module wdt_count_chain import wdt_pkg::*; #(
  parameter int CW = 35,
  parameter int SHRINK = 0
) (
  input wire logic sys_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic restart, // clear the chain
  input wire logic [5:0] exponent, // timeout is two to this minus SHRINK
  output logic expire // one-cycle timeout pulse
);
  // elaboration check: the chain must hold the longest period
  if (CW < EXP_MAX + 1 || SHRINK < 0 || SHRINK > 14) begin : g_bad_params
    $error("wdt_count_chain: bad parameters");
  end

  logic [CW-1:0] count; // free-running chain
  logic [CW-1:0] next_count;
  logic next_expire;
  logic [5:0] eff; // exponent after shrink
  logic [CW-1:0] lim; // last count before timeout

  // chain counts every clock; no idle or stop gating, so sleep cannot halt it
  always_comb begin
    eff = exponent - 6'(SHRINK);
    lim = (CW'(1) << eff) - CW'(1);
    next_count = count + CW'(1);
    next_expire = 1'b0;
    if (restart) begin
      next_count = '0;
    end else if (count >= lim) begin
      // >= covers a shorter period chosen mid-count
      next_count = '0;
      next_expire = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      expire <= 1'b0;
    end else begin
      count <= next_count;
      expire <= next_expire;
    end
  end
endmodule : wdt_count_chain

// ### hdl/wdt_timed_access.sv
`timescale 1ns/1ns
module wdt_timed_access import wdt_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic key_wr, // write to the key register
  input wire logic [7:0] key_data, // written key byte
  input wire logic prot_wr, // protected register write
  output logic unlocked // protected write allowed now
);
  wdt_ta_state_t state;
  wdt_ta_state_t next_state;
  logic [3:0] age; // cycles since last step
  logic [3:0] next_age;

  // two keys in order, then one protected write, all inside the window
  always_comb begin
    next_state = state;
    next_age = age + 4'h1;
    case (state)
      TA_IDLE: begin
        next_age = 4'h0;
        if (key_wr && key_data == TA_KEY1) begin
          next_state = TA_HALF;
        end
      end
      TA_HALF: begin
        if (key_wr) begin
          next_age = 4'h0;
          next_state = (key_data == TA_KEY2) ? TA_OPEN : TA_IDLE;
        end else if (age >= 4'(TA_WINDOW - 1)) begin
          next_state = TA_IDLE;
        end
      end
      TA_OPEN: begin
        // any use, a new key write, or the window ending closes it
        if (prot_wr || key_wr || age >= 4'(TA_WINDOW - 1)) begin
          next_state = TA_IDLE;
        end
      end
      default: next_state = TA_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= TA_IDLE;
      age <= 4'h0;
    end else begin
      state <= next_state;
      age <= next_age;
    end
  end

  assign unlocked = (state == TA_OPEN);
endmodule : wdt_timed_access

// ### hdl/wdt_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - free-running count sets timeout flag bit 3
// - four periods, each eight times longer
// - standard and power-save exponent tables
// - period select sits at clock control 7:6
// - multiplier and divide field change the period
// - divide field resets to divide-by-four
// - vector 63h when both enables set
// - core reset 512 clocks after flag
// - enable and restart writes need timed access
// - watchdog reset sets cause flag bit 2
// - flag sets regardless of interrupt enable
// - counting continues in power-saving modes
// - priority bit 4 raises; natural rank 14
module wdt_top import wdt_pkg::*; #(
  parameter int SHRINK = 0 // exponent reduction for simulation
) (
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic resetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  output logic irq, // masked status interrupt
  output logic wd_irq_req, // vectored request to core
  output logic wd_irq_high, // request is high priority
  output logic [7:0] wd_irq_vector, // service address
  output logic [3:0] wd_irq_rank, // natural tie-break rank
  output logic cpu_reset // one-cycle core reset pulse
);
  // elaboration check: too much shrink leaves no usable period
  if (SHRINK < 0 || SHRINK > 14) begin : g_bad_shrink
    $error("wdt_top: SHRINK out of range");
  end

  // bus capture
  logic wr_pend; // write data phase pending
  logic [7:0] wr_addr; // address of pending write
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;

  // software-visible state
  logic tof; // timeout flag
  logic rcf; // reset cause flag
  logic rfe; // reset function enable
  logic [1:0] psel; // period select
  logic [1:0] cdiv; // clock divide field
  logic mult; // multiplier factor
  logic gie; // global enable
  logic toie; // timeout interrupt enable
  logic toip; // timeout priority
  logic [ST_W-1:0] stat; // sticky events
  logic [ST_W-1:0] mask; // event mask
  logic next_tof;
  logic next_rcf;
  logic next_rfe;
  logic [1:0] next_psel;
  logic [1:0] next_cdiv;
  logic next_mult;
  logic next_gie;
  logic next_toie;
  logic next_toip;
  logic [ST_W-1:0] next_stat;
  logic [ST_W-1:0] next_mask;

  // grace countdown
  wdt_wd_state_t wstate;
  wdt_wd_state_t next_wstate;
  logic [9:0] grace; // clocks since timeout
  logic [9:0] next_grace;
  logic next_cpu_reset;

  // decoded strobes
  logic addr_ph; // valid address phase here
  logic rd_ph; // read address phase
  logic wd_wr; // data-phase write enable
  logic prot_ok; // timed access open
  logic restart_sw; // protected restart write
  logic restart; // any chain restart
  logic expire; // timeout pulse
  logic [5:0] exponent;

  // only nonseq/seq transfers with hready are taken
  assign addr_ph = hsel && htrans[1] && hready;
  assign rd_ph = addr_ph && !hwrite;
  assign wd_wr = wr_pend;

  // read mux function for one offset
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == OFS_GUARD) begin
      v[GD_TOF] = tof;
      v[GD_RCF] = rcf;
      v[GD_RFE] = rfe;
    end else if (a == OFS_CLKCTL) begin
      v[PS_HI] = psel[1];
      v[PS_LO] = psel[0];
    end else if (a == OFS_PWR) begin
      v[CD_HI] = cdiv[1];
      v[CD_LO] = cdiv[0];
      v[MULT_BIT] = mult;
    end else if (a == OFS_IE) begin
      v[GIE_BIT] = gie;
    end else if (a == OFS_XIE) begin
      v[TOIE_BIT] = toie;
    end else if (a == OFS_XIP) begin
      v[TOIP_BIT] = toip;
    end else if (a == OFS_STAT) begin
      v[ST_W-1:0] = stat;
    end else if (a == OFS_MASK) begin
      v[ST_W-1:0] = mask;
    end
    rd_word = v;
  endfunction : rd_word

  // timed access sequencer
  // key pair gate
  wdt_timed_access u_ta (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .key_wr(wd_wr && wr_addr == OFS_TA),
    .key_data(hwdata[7:0]),
    .prot_wr(wd_wr && wr_addr == OFS_GUARD),
    .unlocked(prot_ok)
  );

  assign exponent = wdt_exponent(cdiv, mult, psel);

  assign restart_sw = wd_wr && wr_addr == OFS_GUARD && prot_ok && hwdata[GD_RST];
  assign restart = restart_sw || cpu_reset;

  wdt_count_chain #(
    .CW(EXP_MAX + 1),
    .SHRINK(SHRINK)
  ) u_chain (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .restart(restart),
    .exponent(exponent),
    .expire(expire)
  );

  // bus phase tracking and registered read data
  always_comb begin
    next_wr_pend = addr_ph && hwrite;
    next_wr_addr = haddr[7:0];
    next_hrdata = hrdata;
    if (rd_ph) begin
      next_hrdata = rd_word(haddr[7:0]);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  // zero-wait-state slave, never an error
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // register writes and hardware flag updates
  always_comb begin
    next_tof = tof;
    next_rcf = rcf;
    next_rfe = rfe;
    next_psel = psel;
    next_cdiv = cdiv;
    next_mult = mult;
    next_gie = gie;
    next_toie = toie;
    next_toip = toip;
    next_mask = mask;
    next_stat = stat;
    if (wd_wr) begin
      if (wr_addr == OFS_GUARD) begin
        next_tof = hwdata[GD_TOF];
        next_rcf = hwdata[GD_RCF];
        if (prot_ok) begin
          next_rfe = hwdata[GD_RFE];
        end
      end else if (wr_addr == OFS_CLKCTL) begin
        next_psel = {hwdata[PS_HI], hwdata[PS_LO]};
      end else if (wr_addr == OFS_PWR) begin
        next_cdiv = {hwdata[CD_HI], hwdata[CD_LO]};
        next_mult = hwdata[MULT_BIT];
      end else if (wr_addr == OFS_IE) begin
        next_gie = hwdata[GIE_BIT];
      end else if (wr_addr == OFS_XIE) begin
        next_toie = hwdata[TOIE_BIT];
      end else if (wr_addr == OFS_XIP) begin
        next_toip = hwdata[TOIP_BIT];
      end else if (wr_addr == OFS_MASK) begin
        next_mask = hwdata[ST_W-1:0];
      end
    end
    // status clears on its read; the events below still win
    if (rd_ph && haddr[7:0] == OFS_STAT) begin
      next_stat = '0;
    end
    if (expire) begin
      next_tof = 1'b1;
      next_stat[ST_TO] = 1'b1;
    end
    if (next_cpu_reset) begin
      next_rcf = 1'b1;
      next_stat[ST_WR] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tof <= 1'b0;
      rcf <= 1'b0;
      rfe <= 1'b0;
      psel <= PS_RESET;
      cdiv <= CD_RESET;
      mult <= 1'b0;
      gie <= 1'b0;
      toie <= 1'b0;
      toip <= 1'b0;
      mask <= '0;
      stat <= '0;
    end else begin
      tof <= next_tof;
      rcf <= next_rcf;
      rfe <= next_rfe;
      psel <= next_psel;
      cdiv <= next_cdiv;
      mult <= next_mult;
      gie <= next_gie;
      toie <= next_toie;
      toip <= next_toip;
      mask <= next_mask;
      stat <= next_stat;
    end
  end

  // grace countdown from flag to core reset
  always_comb begin
    next_wstate = wstate;
    next_grace = grace + 10'h001;
    next_cpu_reset = 1'b0;
    case (wstate)
      WD_RUN: begin
        next_grace = 10'h000;
        if (expire && !restart) begin
          next_wstate = WD_GRACE;
        end
      end
      WD_GRACE: begin
        if (restart) begin
          next_wstate = WD_RUN;
        end else if (grace == 10'(GRACE_CLKS - 1)) begin
          next_cpu_reset = rfe;
          next_wstate = WD_RUN;
        end
      end
      default: next_wstate = WD_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wstate <= WD_RUN;
      grace <= 10'h000;
      cpu_reset <= 1'b0;
    end else begin
      wstate <= next_wstate;
      grace <= next_grace;
      cpu_reset <= next_cpu_reset;
    end
  end

  assign wd_irq_req = tof && toie && gie;
  assign wd_irq_high = toip;
  assign wd_irq_rank = IRQ_RANK;
  assign wd_irq_vector = IRQ_VECTOR;
  // level interrupt while any unmasked event is pending
  assign irq = |(stat & mask);
endmodule : wdt_top

// ### tb/wdt_top_sva.sv
`timescale 1ns/1ns
module wdt_top_sva import wdt_pkg::*; #(
  parameter int SHRINK = 0 // same reduction as the block
) (
  input wire logic sys_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [31:0] hwdata, // write data
  input wire logic hreadyout, // slave ready, also the bus ready
  input wire logic hresp, // response
  input wire logic [31:0] hrdata, // read data
  input wire logic wd_irq_req, // vectored request
  input wire logic wd_irq_high, // high priority
  input wire logic cpu_reset // core reset pulse
);
  logic rd_ph, next_rd_ph; // read data phase
  logic wr_ph, next_wr_ph; // write data phase
  logic [7:0] ph_addr, next_ph_addr; // offset in the data phase
  logic [9:0] gap, next_gap; // clocks since last core reset, saturating
  // follow each accepted transfer into its data phase
  always_comb begin
    next_rd_ph = hsel & htrans[1] & hreadyout & ~hwrite;
    next_wr_ph = hsel & htrans[1] & hreadyout & hwrite;
    next_ph_addr = (hsel & htrans[1] & hreadyout) ? haddr[7:0] : ph_addr;
    next_gap = cpu_reset ? 10'h000 : ((gap == 10'h3FF) ? gap : gap + 10'h001);
  end
  // saturating start so the first reset is never judged too early
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_ph <= 1'b0;
      wr_ph <= 1'b0;
      ph_addr <= 8'h00;
      gap <= 10'h3FF;
    end else begin
      rd_ph <= next_rd_ph;
      wr_ph <= next_wr_ph;
      ph_addr <= next_ph_addr;
      gap <= next_gap;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered an error");
  a_rdata_hold: assert property (!(hsel && htrans[1] && hreadyout && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_prio_hold: assert property (!(wr_ph && ph_addr == OFS_XIP) |=> $stable(wd_irq_high))
    else $error("priority output changed without its write");
  a_prio_follow: assert property (wr_ph && ph_addr == OFS_XIP |=> wd_irq_high == $past(hwdata[4]))
    else $error("priority output does not follow its bit");
  a_reset_pulse: assert property (cpu_reset |=> !cpu_reset)
    else $error("core reset longer than one clock");
  a_reset_gap: assert property (cpu_reset |-> gap >= 10'h200)
    else $error("core resets closer than the grace time");
  a_flag_sticky: assert property ($fell(wd_irq_req) |-> $past(wr_ph))
    else $error("request dropped without a register write");
  a_restart_zero: assert property (rd_ph && ph_addr == OFS_GUARD |-> !hrdata[0])
    else $error("restart bit reads back set");
  a_unmapped_zero: assert property (rd_ph && (ph_addr == OFS_TA || ph_addr > OFS_MASK) |-> hrdata == 32'h0)
    else $error("unmapped or key read not zero");
  a_upper_zero: assert property (rd_ph |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  c_core_reset: cover property (cpu_reset);
  c_request: cover property ($rose(wd_irq_req));
  c_prio: cover property ($rose(wd_irq_high));
endmodule : wdt_top_sva

// ### tb/wdt_core_model.sv
`timescale 1ns/1ns
module wdt_core_model import wdt_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  input wire logic cpu_reset, // core reset request
  output logic hsel, // slave select
  output logic [31:0] haddr, // byte address
  output logic [1:0] htrans, // transfer type
  output logic hwrite, // write when high
  output logic [2:0] hsize, // always a word
  output logic [31:0] hwdata, // write data
  output int resets // core resets seen
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    resets = 0;
  end
  // the core only counts resets; the block keeps its registers
  always @(posedge sys_clk) if (cpu_reset === 1'b1) resets <= resets + 1;
  // one single word transfer; waits as long as the slave asks
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? wd : ~hwdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    // released data lines do not keep the last value
    hwdata <= ~hwdata;
  endtask : xfer
  task prot(input logic [7:0] v);
    logic [31:0] x;
    xfer(1'b1, OFS_TA, {24'h0, TA_KEY1}, x);
    xfer(1'b1, OFS_TA, {24'h0, TA_KEY2}, x);
    xfer(1'b1, OFS_GUARD, {24'h0, v}, x);
  endtask : prot
endmodule : wdt_core_model

// ### tb/wdt_top_test.sv
`timescale 1ns/1ns
module wdt_top_test import wdt_pkg::*;;
  logic sys_clk = 1'b0; // 100 MHz
  logic resetn = 1'b0; // held low at start
  logic hsel, hwrite, hreadyout, hresp, irq; // bus and status lines
  logic wd_irq_req, wd_irq_high, cpu_reset; // core side
  logic [31:0] haddr, hwdata, hrdata, rv, rnd; // bus words
  logic [1:0] htrans, cd, ps; // transfer type, divide, select
  logic [2:0] hsize; // transfer size
  logic [7:0] wd_irq_vector; // service address
  logic [3:0] wd_irq_rank; // tie-break rank
  logic [7:0] ofs [9] = '{8'h00, 8'h1C, 8'h20, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h24};
  int err_total = 0, total_checks = 0, seed = 96842, cyc = 0, t0, t, n0, resets;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  wdt_top #(.SHRINK(12)) DUT (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .wd_irq_req,
    .wd_irq_high, .wd_irq_vector, .wd_irq_rank, .cpu_reset);
  wdt_core_model core (.sys_clk, .hready(hreadyout), .hrdata, .cpu_reset, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .resets);
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task rd(input logic [7:0] a);
    core.xfer(1'b0, a, 32'h0, rv);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, rv);
  endtask : wr
  // bounded wait for the vectored request
  task wait_req(input int lim);
    t0 = cyc;
    do @(posedge sys_clk); while (wd_irq_req !== 1'b1 && cyc - t0 < lim);
  endtask : wait_req
  // timeout length in clocks with the simulation reduction of 12
  function automatic int span(logic [1:0] c, logic m, logic [1:0] p);
    int b;
    b = (c == 2'h3) ? 25 : ((c == 2'h0) ? (m ? 15 : 16) : 17);
    return 2 ** (b + 3 * p - 12);
  endfunction : span
  task print_verdict;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    #1000000;
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(ofs[i]);
      check("reset value", rv, (ofs[i] == OFS_PWR) ? 32'h80 : 32'h0);
    end
    check("service address", {24'h0, wd_irq_vector}, 32'h63);
    check("natural rank", {28'h0, wd_irq_rank}, 32'hE);
    $display("test reset values done");
    wr(OFS_IE, 32'h80);
    wr(OFS_XIE, 32'h10);
    for (int i = 0; i < 7; i++) begin
      rnd = $random(seed);
      cd = (rnd[1:0] == 2'h3) ? 2'h2 : rnd[1:0];
      ps = (rnd[9:8] == 2'h3 && cd != 2'h0) ? 2'h2 : rnd[9:8];
      if (i == 6) cd = 2'h3;
      if (i == 6) ps = 2'h0;
      t = span(cd, rnd[4], ps);
      wr(OFS_PWR, {24'h0, cd, 2'h0, rnd[4], 3'h0});
      wr(OFS_CLKCTL, {24'h0, ps, 6'h0});
      core.prot(8'h01);
      n0 = cyc;
      wr(OFS_GUARD, 32'h0);
      wait_req(t + 16);
      check("timeout span", {31'h0, (cyc - n0 >= t - 2) && (cyc - n0 <= t + 2)}, 32'h1);
    end
    $display("test timeout periods done");
    wr(OFS_PWR, 32'h80);
    wr(OFS_CLKCTL, 32'h40);
    wr(OFS_IE, 32'h0);
    core.prot(8'h01);
    rd(OFS_STAT);
    repeat (270) @(posedge sys_clk);
    check("request gated", {31'h0, wd_irq_req}, 32'h0);
    check("masked irq", {31'h0, irq}, 32'h0);
    rd(OFS_GUARD);
    check("timeout flag", {31'h0, rv[3]}, 32'h1);
    wr(OFS_IE, 32'h80);
    wr(OFS_MASK, 32'h1);
    @(posedge sys_clk);
    check("request open", {31'h0, wd_irq_req}, 32'h1);
    check("irq level", {31'h0, irq}, 32'h1);
    rd(OFS_STAT);
    check("status event", rv, 32'h1);
    @(posedge sys_clk);
    check("irq after read", {31'h0, irq}, 32'h0);
    rnd = $random(seed);
    wr(OFS_XIP, rnd);
    @(posedge sys_clk);
    check("priority", {31'h0, wd_irq_high}, {31'h0, rnd[4]});
    $display("test interrupts done");
    // only the full key sequence opens
    for (int m = 0; m < 4; m++) begin
      if (m == 1) wr(OFS_TA, {24'h0, TA_KEY2});
      if (m > 0 && m < 3) wr(OFS_TA, {24'h0, TA_KEY1});
      if (m == 2) wr(OFS_TA, {24'h0, TA_KEY2});
      if (m == 2) repeat (12) @(posedge sys_clk);
      if (m < 3) wr(OFS_GUARD, 32'h2);
      else core.prot(8'h02);
      rd(OFS_GUARD);
      check("reset enable", {31'h0, rv[1]}, {31'h0, m == 3});
    end
    $display("test timed access done");
    // reset exactly after the grace time
    wr(OFS_CLKCTL, 32'h0);
    core.prot(8'h03);
    wr(OFS_GUARD, 32'h0);
    wait_req(100);
    t0 = cyc;
    n0 = resets;
    while (cpu_reset !== 1'b1 && cyc - t0 < 600) @(posedge sys_clk);
    check("reset delay", 32'(cyc - t0), 32'd512);
    @(posedge sys_clk);
    check("reset count", 32'(resets), 32'(n0 + 1));
    rd(OFS_GUARD);
    check("reset cause", {31'h0, rv[2]}, 32'h1);
    rd(OFS_STAT);
    check("status reset", {31'h0, rv[1]}, 32'h1);
    wr(OFS_GUARD, 32'h0);
    wait_req(100);
    repeat (100) @(posedge sys_clk);
    n0 = resets;
    // restart with reset still enabled: the old countdown would fire in 402 clocks
    core.prot(8'h03);
    repeat (500) @(posedge sys_clk);
    check("no reset", 32'(resets), 32'(n0));
    // disabling the reset function keeps later countdowns harmless
    core.prot(8'h01);
    repeat (700) @(posedge sys_clk);
    check("reset disabled", 32'(resets), 32'(n0));
    $display("test core reset done");
    print_verdict;
  end
endmodule : wdt_top_test
bind wdt_top wdt_top_sva #(.SHRINK(SHRINK)) chk (.sys_clk, .resetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hreadyout, .hresp, .hrdata, .wd_irq_req, .wd_irq_high, .cpu_reset);
